// ### rtl/sar_pkg.sv
// Shared constants, types and helper functions of the simultaneous converter readout.
package sar_pkg;

  // ----------------------------------------------------------------
  // Clock, word and channel geometry
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned CHANNELS_MAX = 8;
  localparam int unsigned OSR = 64;
  localparam int unsigned ONES_BITS = 7;
  localparam int unsigned PHASE_BITS = 6;
  localparam int unsigned DIV_BITS = 6;

  // ----------------------------------------------------------------
  // Master clock to modulator clock ratios and conversion limits
  // ----------------------------------------------------------------
  localparam logic [5:0] DIV_HS_SEL0 = 6'h04;
  localparam logic [5:0] DIV_HS_SEL1 = 6'h08;
  localparam logic [5:0] DIV_LP_SEL0 = 6'h08;
  localparam logic [5:0] DIV_LP_SEL1 = 6'h28;
  localparam int unsigned CONV_MIN_CLKS = 256;
  localparam int unsigned CONV_MAX_CLKS = 2560;
  // Output rates reached with the fastest permitted master clock.
  localparam int unsigned RATE_HS_SPS = 52734;
  localparam int unsigned RATE_LP_SPS = 10547;

  // ----------------------------------------------------------------
  // Result coding
  // ----------------------------------------------------------------
  localparam logic [15:0] CODE_POS_FULL = 16'h7fff;
  localparam logic [15:0] CODE_NEG_FULL = 16'h8000;
  localparam int unsigned CODE_LSB_SHIFT = 10;

  // Readout sequencer states.
  typedef enum logic [1:0] {RD_IDLE, RD_READY, RD_SHIFT} sar_rd_state_t;

  // Modulator clock divisor for a given speed mode and divide select.
  function automatic logic [5:0] mod_divisor(input logic low_power, input logic div_sel);
    logic [5:0] d;
    d = DIV_HS_SEL0;
    if (low_power && div_sel)
      d = DIV_LP_SEL1;
    else if (low_power)
      d = DIV_LP_SEL0;
    else if (div_sel)
      d = DIV_HS_SEL1;
    return d;
  endfunction

  // Ones density over one decimation window turned into two's complement.
  function automatic logic [15:0] density_code(input logic [6:0] ones);
    logic [15:0] code;
    code = CODE_POS_FULL;
    if (ones < 7'(OSR))
      code = CODE_NEG_FULL + 16'(16'(ones) << CODE_LSB_SHIFT);
    return code;
  endfunction

endpackage

// ### rtl/sar_conv_if.sv
// Link between the readout control and the decimating filter bank.
`timescale 1ns/1ps
interface sar_conv_if #(parameter int unsigned NCH = 8);
  logic mod_en;
  logic restart;
  logic [NCH-1:0] mod_bits;
  logic done;
  logic [NCH*sar_pkg::WORD_BITS-1:0] words;
  modport dec (input mod_en, input restart, input mod_bits, output done, output words);
  modport ctl (output mod_en, output restart, output mod_bits, input done, input words);
endinterface

// ### rtl/sar_decim.sv
// Bank of decimating filters, one per channel, sharing one modulator clock enable.
`timescale 1ns/1ps
module sar_decim #(
  parameter int unsigned NCH = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Link to the readout control.
  sar_conv_if.dec cv
);

  localparam int unsigned OB = sar_pkg::ONES_BITS;
  localparam int unsigned WB = sar_pkg::WORD_BITS;
  localparam logic [5:0] PH_LAST = 6'(sar_pkg::OSR - 1);

  logic [sar_pkg::PHASE_BITS-1:0] phase_ff;
  logic [NCH*OB-1:0] ones_ff;
  logic [NCH*WB-1:0] words_ff;
  logic done_ff;
  logic [OB-1:0] smp_ff;

  assign cv.done = done_ff;
  assign cv.words = words_ff;

  // Position inside the decimation window; a sync restart realigns all channels.
  always_ff @(posedge clk)
  begin
    if (!rstn || cv.restart)
      phase_ff <= '0;
    else if (cv.mod_en)
      phase_ff <= phase_ff + 6'h01;
  end

  // All channels sample on the same enable, so their results share one instant.
  always_ff @(posedge clk)
  begin
    if (!rstn || cv.restart)
      ones_ff <= '0;
    else if (cv.mod_en)
      for (int c = 0; c < NCH; c++)
        ones_ff[c*OB +: OB] <= (phase_ff == PH_LAST) ? '0 :
                               ones_ff[c*OB +: OB] + 7'(cv.mod_bits[c]);
  end

  // Channel 0 sits in the top word so that the serial chain reads it first.
  always_ff @(posedge clk)
  begin
    if (!rstn)
      words_ff <= '0;
    else if (cv.mod_en && phase_ff == PH_LAST)
      for (int c = 0; c < NCH; c++)
        words_ff[(NCH-1-c)*WB +: WB] <=
          sar_pkg::density_code(ones_ff[c*OB +: OB] + 7'(cv.mod_bits[c]));
  end

  // One result strobe per window of modulator samples.
  always_ff @(posedge clk)
  begin
    if (!rstn || cv.restart)
      done_ff <= 1'b0;
    else
      done_ff <= cv.mod_en && phase_ff == PH_LAST;
  end

  // Helper count of modulator samples between result strobes.
  always_ff @(posedge clk)
  begin
    if (!rstn || cv.restart)
      smp_ff <= '0;
    else if (done_ff)
      smp_ff <= 7'(cv.mod_en);
    else if (cv.mod_en)
      smp_ff <= smp_ff + 7'h01;
  end

  a_window_length: assert property (@(posedge clk) disable iff (!rstn)
    done_ff |-> smp_ff == 7'(sar_pkg::OSR))
    else $error("result strobe not after one full decimation window");

  a_full_scale_code: assert property (@(posedge clk) disable iff (!rstn || cv.restart)
    (cv.mod_en && phase_ff == PH_LAST && cv.mod_bits[0] && ones_ff[OB-1:0] == 7'(PH_LAST))
    |=> words_ff[NCH*WB-1 -: WB] == sar_pkg::CODE_POS_FULL)
    else $error("all-ones density did not give positive full scale");

endmodule

// ### rtl/sar_readout.sv
// Top of the simultaneous converter readout: clocking, decimation and serial port.
//
// Function
// - One conversion result per period of 256 to 2560 master clocks.
// - MSB appears when ready falls, or when the frame strobe rises.
// - Each falling serial clock edge advances the output to the next bit.
// - Chain input is captured on the falling serial clock edge.
// - SPI mode: ready returns high after a falling serial clock edge.
// - Four or eight converters sample simultaneously, giving 16-bit results.
// - All configuration comes from pins; there are no registers.
// - Modulators run at 64 times the output rate, decimated to one result.
// - High-speed mode gives 52,734 and low-power mode 10,547 samples per second.
// - Chained serial output for cascading; conversions sync to an external event.
// - Shared strobe pin: frame input in frame mode, ready output in SPI mode.
// - Speed pin low selects high speed, high selects low power.
// - Results are two's complement, full scale 7fff and 8000.
`timescale 1ns/1ps
module sar_readout #(
  parameter int unsigned NCH = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Configuration pins.
  input wire logic mode_low_power,
  input wire logic clock_divide_select,
  input wire logic format_frame_sync,
  input wire logic sync_n,
  // Modulator bit streams, one per channel.
  input wire logic [NCH-1:0] mod_bits,
  // Serial port.
  input wire logic sclk,
  input wire logic din,
  input wire logic frame_strobe_i,
  output logic conversion_ready_n_o,
  output logic conversion_ready_n_oe,
  output logic [NCH-1:0] dout
);

  localparam int unsigned WB = sar_pkg::WORD_BITS;
  localparam int unsigned SW = NCH * WB;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sar_conv_if #(.NCH(NCH)) cv ();

  logic [sar_pkg::DIV_BITS-1:0] div_cnt_ff;
  logic [sar_pkg::DIV_BITS-1:0] divisor;
  logic mod_en_ff;
  logic fmt_ff;
  logic sclk_ff;
  logic fs_ff;
  logic sclk_fall;
  logic fs_rise;
  logic load;
  logic [SW-1:0] latest_ff;
  logic [SW-1:0] load_words;
  logic [SW-1:0] sh_ff;
  logic [SW-1:0] nxt_sh;
  sar_pkg::sar_rd_state_t rd_state_ff;
  sar_pkg::sar_rd_state_t nxt_rd_state;
  logic ready_n_ff;
  logic oe_ff;
  logic [NCH-1:0] dout_ff;
  logic [sar_pkg::DIV_BITS-1:0] gap_ff;
  logic gap_valid_ff;
  logic [1:0] cfg_ff;

  // ----------------------------------------------------------------
  // Modulator clock and decimation
  // ----------------------------------------------------------------
  // Configuration lives on pins only, so the divisor follows them directly.
  assign divisor = sar_pkg::mod_divisor(mode_low_power, clock_divide_select);

  // A sync pulse restarts the divider so every device lines up on one event.
  always_ff @(posedge clk)
  begin
    if (!rstn || !sync_n)
      div_cnt_ff <= '0;
    else if (div_cnt_ff >= divisor - 6'h01)
      div_cnt_ff <= '0;
    else
      div_cnt_ff <= div_cnt_ff + 6'h01;
  end

  // One-cycle modulator clock enable at the selected ratio.
  always_ff @(posedge clk)
  begin
    if (!rstn || !sync_n)
      mod_en_ff <= 1'b0;
    else
      mod_en_ff <= div_cnt_ff >= divisor - 6'h01;
  end

  assign cv.mod_en = mod_en_ff;
  assign cv.restart = !sync_n;
  assign cv.mod_bits = mod_bits;

  sar_decim #(.NCH(NCH)) u_decim (
    .clk(clk),
    .rstn(rstn),
    .cv(cv)
  );

  // ----------------------------------------------------------------
  // Pin sampling and edge detection
  // ----------------------------------------------------------------
  // Inputs are synchronous, so one register suffices for edge detection.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sclk_ff <= 1'b0;
      fs_ff <= 1'b0;
      fmt_ff <= 1'b0;
    end
    else
    begin
      sclk_ff <= sclk;
      fs_ff <= frame_strobe_i;
      fmt_ff <= format_frame_sync;
    end
  end

  assign sclk_fall = sclk_ff && !sclk;
  assign fs_rise = !fs_ff && frame_strobe_i;

  // Newest results are kept for frame mode, where the host picks the moment.
  always_ff @(posedge clk)
  begin
    if (!rstn)
      latest_ff <= '0;
    else if (cv.done)
      latest_ff <= cv.words;
  end

  // ----------------------------------------------------------------
  // Shift chain
  // ----------------------------------------------------------------
  // SPI loads on every new result; frame mode loads on the frame strobe edge.
  assign load = fmt_ff ? fs_rise : cv.done;
  assign load_words = cv.done ? cv.words : latest_ff;

  // All channel words form one chain; chain input enters below the last one.
  always_comb
  begin
    nxt_sh = sh_ff;
    if (load)
      nxt_sh = load_words;
    else if (sclk_fall)
      nxt_sh = {sh_ff[SW-2:0], din};
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      sh_ff <= '0;
    else
      sh_ff <= nxt_sh;
  end

  // Each output shows the MSB of its channel word slot.
  always_ff @(posedge clk)
  begin
    if (!rstn)
      dout_ff <= '0;
    else
      for (int k = 0; k < NCH; k++)
        dout_ff[k] <= nxt_sh[(NCH-k)*WB-1];
  end

  assign dout = dout_ff;

  // ----------------------------------------------------------------
  // Conversion ready sequencing
  // ----------------------------------------------------------------
  // A new result always wins over a clock edge in the same cycle, so none is lost.
  always_comb
  begin
    nxt_rd_state = rd_state_ff;
    case (rd_state_ff)
      sar_pkg::RD_IDLE:
        if (!fmt_ff && cv.done)
          nxt_rd_state = sar_pkg::RD_READY;
      sar_pkg::RD_READY:
        if (fmt_ff)
          nxt_rd_state = sar_pkg::RD_IDLE;
        else if (cv.done)
          nxt_rd_state = sar_pkg::RD_READY;
        else if (sclk_fall)
          nxt_rd_state = sar_pkg::RD_SHIFT;
      sar_pkg::RD_SHIFT:
        if (fmt_ff)
          nxt_rd_state = sar_pkg::RD_IDLE;
        else if (cv.done)
          nxt_rd_state = sar_pkg::RD_READY;
      default:
        nxt_rd_state = sar_pkg::RD_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      rd_state_ff <= sar_pkg::RD_IDLE;
    else
      rd_state_ff <= nxt_rd_state;
  end

  // Ready is low only while a fresh result waits; the pin is driven in SPI mode only.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ready_n_ff <= 1'b1;
      oe_ff <= 1'b0;
    end
    else
    begin
      ready_n_ff <= nxt_rd_state != sar_pkg::RD_READY;
      oe_ff <= !format_frame_sync;
    end
  end

  assign conversion_ready_n_o = ready_n_ff;
  assign conversion_ready_n_oe = oe_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Helper: cycles between modulator enables while configuration is steady.
  always_ff @(posedge clk)
  begin
    if (!rstn || !sync_n || cfg_ff != {mode_low_power, clock_divide_select})
    begin
      gap_ff <= '0;
      gap_valid_ff <= 1'b0;
    end
    else if (mod_en_ff)
    begin
      gap_ff <= '0;
      gap_valid_ff <= 1'b1;
    end
    else
      gap_ff <= gap_ff + 6'h01;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      cfg_ff <= '0;
    else
      cfg_ff <= {mode_low_power, clock_divide_select};
  end

  sequence s_ready_drop;
    $fell(conversion_ready_n_o);
  endsequence

  sequence s_spi_release;
    !fmt_ff && rd_state_ff == sar_pkg::RD_READY && sclk_fall && !cv.done;
  endsequence

  a_mod_ratio: assert property (@(posedge clk) disable iff (!rstn || !sync_n)
    (mod_en_ff && gap_valid_ff) |-> gap_ff == divisor - 6'h01)
    else $error("modulator enable spacing does not match mode and divide select");

  a_ready_msb: assert property (@(posedge clk) disable iff (!rstn)
    s_ready_drop |-> dout_ff[0] == latest_ff[SW-1] && dout_ff[NCH-1] == latest_ff[WB-1])
    else $error("MSB not present when ready fell");

  a_frame_msb: assert property (@(posedge clk) disable iff (!rstn)
    (fmt_ff && fs_rise && !cv.done) |=> dout_ff[0] == $past(latest_ff[SW-1]))
    else $error("MSB not present after frame strobe rise");

  a_shift_next: assert property (@(posedge clk) disable iff (!rstn)
    (sclk_fall && !load) |=> dout_ff[0] == $past(sh_ff[SW-2]))
    else $error("output did not advance on falling serial clock");

  a_chain_capture: assert property (@(posedge clk) disable iff (!rstn)
    (sclk_fall && !load) |=> sh_ff[0] == $past(din))
    else $error("chain input not captured on falling serial clock");

  a_ready_release: assert property (@(posedge clk) disable iff (!rstn)
    s_spi_release |=> conversion_ready_n_o ##1 (conversion_ready_n_o || $past(cv.done)))
    else $error("ready did not return high after shifting began");

  a_pin_direction: assert property (@(posedge clk) disable iff (!rstn)
    format_frame_sync |=> !conversion_ready_n_oe ##1 conversion_ready_n_o)
    else $error("strobe pin driven in frame mode");

  a_ready_on_result: assert property (@(posedge clk) disable iff (!rstn)
    (!fmt_ff && cv.done) |=> !conversion_ready_n_o)
    else $error("ready did not fall on a new result");

endmodule

// ### verification/sar_host_model.sv
// Host controller model that reads the converter's serial port.
`timescale 1ns/1ps
module sar_host_model #(
  parameter int unsigned NCH = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Requests from the bench.
  input wire logic frame_mode,
  input wire logic start,
  input wire logic [5:0] nfalls,
  input wire logic [3:0] half,
  input wire logic [15:0] din_word,
  // Serial port.
  input wire logic strobe_pin,
  input wire logic [NCH-1:0] dout,
  output logic sclk,
  output logic frame_strobe,
  output logic din,
  // Collected words.
  output logic busy,
  output logic [NCH-1:0][15:0] rx
);
  logic [4:0] ph;
  logic [5:0] cnt;
  logic armed;
  logic act;
  logic seen;
  logic wrap;
  logic sclk_q;

  // The pin follows on the master falling edge, so serial falls line up with master falls.
  always @(negedge clk)
  begin
    sclk <= sclk_q;
  end

  // A serial period is two phases of at least one master clock each.
  assign wrap = (ph == {half, 1'b0} - 5'h01);
  assign busy = armed | act;

  // Serial clock, frame strobe and capture; in SPI form the clock stands low between reads.
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      sclk_q <= 1'b0;
      frame_strobe <= 1'b0;
      din <= 1'b0;
      ph <= 5'h00;
      cnt <= 6'h00;
      armed <= 1'b0;
      act <= 1'b0;
      seen <= 1'b0;
      rx <= '0;
    end
    else
    begin
      if (start)
        armed <= 1'b1;
      if (frame_mode || act)
      begin
        ph <= wrap ? 5'h00 : ph + 5'h01;
        if (wrap)
          sclk_q <= 1'b0;
        else if (ph + 5'h01 == {1'b0, half})
        begin
          sclk_q <= 1'b1;
          din <= din_word[4'hf - cnt[3:0]];
        end
      end
      // Ready must have been seen low half plus one master clocks before the first rise.
      if (!frame_mode && armed && !act)
      begin
        seen <= !strobe_pin;
        if (seen)
        begin
          act <= 1'b1;
          armed <= 1'b0;
          seen <= 1'b0;
          ph <= 5'h00;
          cnt <= 6'h00;
        end
      end
      if (frame_mode && armed && !act && wrap)
      begin
        frame_strobe <= 1'b1;
        act <= 1'b1;
        armed <= 1'b0;
        cnt <= 6'h00;
      end
      // Bits are taken just before each fall, so the strobe stays high one full period.
      if (act && wrap)
      begin
        frame_strobe <= 1'b0;
        cnt <= cnt + 6'h01;
        for (int k = 0; k < NCH; k++)
          rx[k] <= {rx[k][14:0], dout[k]};
        if (cnt + 6'h01 == nfalls)
          act <= 1'b0;
      end
    end
  end
endmodule

// ### verification/sar_readout_tb.sv
// Self-checking bench for the simultaneous converter readout.
`timescale 1ns/1ps
module sar_readout_tb;
  localparam int unsigned NCH = 8;
  localparam logic [15:0] CHAIN_WORD = 16'h5a3c;
  typedef struct {logic lp; logic ds; logic fr; int div; int nf;} sar_row_t;
  sar_row_t rows[6] = '{'{1'b0, 1'b0, 1'b0, 4, 16}, '{1'b0, 1'b1, 1'b0, 8, 32},
    '{1'b1, 1'b0, 1'b0, 8, 16}, '{1'b1, 1'b1, 1'b0, 40, 32},
    '{1'b0, 1'b0, 1'b1, 4, 32}, '{1'b0, 1'b1, 1'b1, 8, 16}};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic mode_low_power = 1'b0;
  logic clock_divide_select = 1'b0;
  logic format_frame_sync = 1'b0;
  logic sync_n = 1'b1;
  logic [NCH-1:0] mod_bits = '0;
  logic start = 1'b0;
  logic [5:0] nfalls = 6'h10;
  logic [3:0] half = 4'h2;
  int cur_div = 4;
  int tick = 0;
  int error_cnt = 0;
  int checked = 0;
  logic sclk;
  logic din;
  logic host_strobe;
  logic busy;
  logic ready_n;
  logic ready_oe;
  logic [NCH-1:0] dout;
  logic [NCH-1:0][15:0] rx;
  logic strobe_pin;

  // The shared strobe pin carries whichever side has it enabled.
  assign strobe_pin = ready_oe ? ready_n : host_strobe;

  // Master clock, 100 MHz.
  always #5 clk = ~clk;

  // Channel patterns whose ones count per window does not depend on the phase.
  always @(posedge clk)
  begin
    tick <= tick + 1;
    for (int k = 0; k < NCH; k++)
      mod_bits[k] <= (k % 4 == 0) || (k % 4 == 2 && (tick / cur_div) % 2 == 1)
        || (k % 4 == 3 && (tick / cur_div) % 4 == 0);
  end

  sar_readout #(.NCH(NCH)) DUT (.clk, .rstn, .mode_low_power, .clock_divide_select,
    .format_frame_sync, .sync_n, .mod_bits, .sclk, .din, .frame_strobe_i(strobe_pin),
    .conversion_ready_n_o(ready_n), .conversion_ready_n_oe(ready_oe), .dout);

  sar_host_model #(.NCH(NCH)) host (.clk, .rstn, .frame_mode(format_frame_sync), .start,
    .nfalls, .half, .din_word(CHAIN_WORD), .strobe_pin, .dout, .sclk,
    .frame_strobe(host_strobe), .din, .busy, .rx);

  // Expected code: 64, 0, 32 and 16 ones per window.
  function automatic logic [15:0] code_of(input int k);
    case (k % 4)
      0: return sar_pkg::CODE_POS_FULL;
      1: return sar_pkg::CODE_NEG_FULL;
      2: return sar_pkg::CODE_NEG_FULL + 16'h8000;
      default: return sar_pkg::CODE_NEG_FULL + 16'h4000;
    endcase
  endfunction

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic chkn(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask

  // Counts edges until ready falls, so a wrong divisor shows as a wrong span.
  task automatic wait_ready(input int lo, input int hi);
    int n;
    n = 0;
    while (ready_n !== 1'b0 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    chkn(n, lo, hi);
  endtask

  task automatic read_port();
    int n;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    @(posedge clk);
    while (busy !== 1'b0 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    chkn(n, 0, 1999);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run of some seven thousand cycles.
  initial
  begin
    #400000;
    error_cnt++;
    results();
  end

  initial
  begin
    int d;
    int n;
    repeat (10) @(posedge clk);
    chk1(ready_n, 1'b1);
    chk1(ready_oe, 1'b0);
    chk16(16'(dout), 16'h0000);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    chk1(ready_oe, 1'b1);
    // No result may appear while conversions are held.
    sync_n <= 1'b0;
    n = 0;
    repeat (600)
    begin
      @(posedge clk);
      if (ready_n !== 1'b1)
        n++;
    end
    chkn(n, 0, 0);
    foreach (rows[i])
    begin
      d = rows[i].div;
      mode_low_power <= rows[i].lp;
      clock_divide_select <= rows[i].ds;
      format_frame_sync <= rows[i].fr;
      cur_div <= d;
      nfalls <= 6'(rows[i].nf);
      half <= rows[i].fr ? 4'h4 : 4'h2;
      sync_n <= 1'b0;
      repeat (4) @(posedge clk);
      sync_n <= 1'b1;
      @(posedge clk);
      chk1(ready_oe, !rows[i].fr);
      if (!rows[i].fr)
        wait_ready(64 * d - 2, 64 * d + 6);
      else
      begin
        repeat (64 * d + 8) @(posedge clk);
        chk1(ready_n, 1'b1);
      end
      read_port();
      for (int k = 0; k < NCH; k++)
        chk16(rx[k], rows[i].nf == 16 ? code_of(k)
          : (k == NCH - 1 ? CHAIN_WORD : code_of(k + 1)));
      if (!rows[i].fr)
        chk1(ready_n, 1'b1);
    end
    // An unread result keeps ready low until the host shifts.
    format_frame_sync <= 1'b0;
    mode_low_power <= 1'b0;
    clock_divide_select <= 1'b0;
    cur_div <= 4;
    nfalls <= 6'h10;
    half <= 4'h2;
    sync_n <= 1'b0;
    repeat (4) @(posedge clk);
    sync_n <= 1'b1;
    @(posedge clk);
    wait_ready(254, 262);
    repeat (300) @(posedge clk);
    chk1(ready_n, 1'b0);
    read_port();
    chk16(rx[0], code_of(0));
    chk1(ready_n, 1'b1);
    results();
  end
endmodule
